// *** scrx_top.sv ***
`timescale 1ns/1ps
module scrx_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic host_cs,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic host_chan_b,
   input wire logic host_ctrl,
   input wire logic [7:0] host_wdata,
   output logic [7:0] host_rdata,
   input wire logic [scrx_pkg::CHANNELS-1:0] rxd,
   input wire logic [scrx_pkg::CHANNELS-1:0] receive_line_clock,
   input wire logic [scrx_pkg::CHANNELS-1:0] dcd_n,
   input wire logic [scrx_pkg::CHANNELS-1:0] cts_n,
   input wire logic [scrx_pkg::CHANNELS-1:0] sync_n,
   input wire logic [scrx_pkg::CHANNELS-1:0] tx_empty,
   input wire logic [scrx_pkg::CHANNELS-1:0] ext_change,
   output logic [scrx_pkg::CHANNELS-1:0] tx_gate,
   output logic [scrx_pkg::CHANNELS-1:0] rx_overrun,
   output logic [scrx_pkg::CHANNELS*16-1:0] rx_crc
);
   import scrx_pkg::*;

   // per-channel register copies; one vector for both channels
   logic [7:0] int_ctrl_q [CHANNELS];
   logic [7:0] rx_ctrl_q [CHANNELS];
   logic [7:0] fmt_q [CHANNELS];
   logic [7:0] tx_ctrl_q [CHANNELS];
   logic [7:0] sec_addr_q [CHANNELS];
   logic [7:0] rx_sync_q [CHANNELS];
   logic [2:0] ptr_q [CHANNELS];
   logic [7:0] vector_q;

   wire ch = host_chan_b;
   wire [2:0] reg_idx = ptr_q[ch];
   wire ctrl_wr = host_cs & host_wr & host_ctrl;
   wire ctrl_rd = host_cs & host_rd & host_ctrl;
   wire data_rd = host_cs & host_rd & ~host_ctrl;
   wire reg_wr = ctrl_wr & (reg_idx != PTR_STATUS);
   wire vector_wr = reg_wr & (reg_idx == PTR_VECTOR) & (ch == 1'(CHAN_B));

   // pointer then access; pointer falls back to zero afterwards
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < CHANNELS; i++) ptr_q[i] <= PTR_STATUS;
      end else if (ctrl_wr | ctrl_rd) begin
         ptr_q[ch] <= (ctrl_wr & (reg_idx == PTR_STATUS)) ? host_wdata[2:0] : PTR_STATUS;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < CHANNELS; i++) begin
            int_ctrl_q[i] <= REG_RESET;
            rx_ctrl_q[i] <= REG_RESET;
            fmt_q[i] <= REG_RESET;
            tx_ctrl_q[i] <= REG_RESET;
            sec_addr_q[i] <= REG_RESET;
            rx_sync_q[i] <= REG_RESET;
         end
      end else if (reg_wr) begin
         if (reg_idx == PTR_INT_CTRL) int_ctrl_q[ch] <= host_wdata;
         if (reg_idx == PTR_RX_CTRL) rx_ctrl_q[ch] <= host_wdata;
         if (reg_idx == PTR_FORMAT) fmt_q[ch] <= host_wdata;
         if (reg_idx == PTR_TX_CTRL) tx_ctrl_q[ch] <= host_wdata;
         if (reg_idx == PTR_SEC_ADDR) sec_addr_q[ch] <= host_wdata;
         if (reg_idx == PTR_RX_SYNC) rx_sync_q[ch] <= host_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) vector_q <= REG_RESET;
      else if (vector_wr) vector_q <= host_wdata;
   end

   wire [7:0] status_w [CHANNELS];
   wire [WORD_W-1:0] head_w [CHANNELS];
   wire [CHANNELS-1:0] has_src;
   wire [1:0] src_w [CHANNELS];

   function automatic logic [15:0] crc_char(input logic [15:0] seed,
         input logic [8:0] d, input logic [3:0] n, input logic [15:0] poly);
      logic [15:0] c;
      logic fb;
      c = seed;
      for (int i = 0; i < 9; i++) begin
         fb = c[15] ^ d[i];
         if (4'(i) < n) c = {c[14:0], 1'b0} ^ (fb ? poly : 16'h0000);
      end
      crc_char = c;
   endfunction

   for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
      logic s_rxd, s_lclk, s_dcd_n, s_cts_n, s_sync_n;
      scrx_sync #(.W(5)) u_sync (
         .clk(clk),
         .rst(rst),
         .d({sync_n[c], cts_n[c], dcd_n[c], receive_line_clock[c], rxd[c]}),
         .q({s_sync_n, s_cts_n, s_dcd_n, s_lclk, s_rxd})
      );

      scrx_stream_if #(.W(WORD_W)) hold_if ();
      scrx_stream_if #(.W(WORD_W)) head_if ();
      scrx_buf2 #(.W(WORD_W), .DEPTH(2)) u_buf (
         .clk(clk),
         .rst(rst),
         .in(hold_if.snk),
         .out(head_if.src)
      );

      wire [7:0] rc = rx_ctrl_q[c];
      wire [7:0] fm = fmt_q[c];
      wire auto_en = rc[RXC_AUTO];
      wire [1:0] sync_mode = fm[FMT_SYNC +: 2];
      wire is_async = fm[FMT_STOP +: 2] != STOP_SYNC_MODE;
      wire is_sdlc = sync_mode == SYNC_SDLC;
      wire rx_go = rc[RXC_ENABLE] & (~auto_en | ~s_dcd_n);
      wire [3:0] nbits = char_bits(rc[RXC_LEN +: 2]);
      wire [3:0] total = nbits + {3'h0, fm[FMT_PAR_EN]};
      wire [6:0] div = rate_ticks(fm[FMT_RATE +: 2]);
      wire [6:0] half = div >> 1;

      logic lclk_prev_q, hunt_q, leading_q, first_q, discard_q, crc_on_q;
      logic hold_valid_q, overrun_q, tx_gate_q;
      scrx_state_t state_q;
      logic [6:0] tick_q;
      logic [3:0] bit_q;
      logic [8:0] shift_q;
      logic [15:0] win_q;
      logic [15:0] crc_q;
      scrx_word_t hold_q;

      wire tick = s_lclk & ~lclk_prev_q;
      wire [15:0] win_n = {s_rxd, win_q[15:1]};
      wire [8:0] shift_n = {s_rxd, shift_q[8:1]};
      wire [8:0] raw = (is_async ? shift_q : shift_n) >> (SHIFT_BITS - total);
      wire bit_end = tick_q == div - 7'h01;
      wire shift_en = is_async ? tick & rx_go & bit_end & (state_q == RX_DATA) : sync_tick;
      wire sync_tick = tick & rx_go & ~is_async;
      wire sync_hit =
         (sync_mode == SYNC_MONO) ? win_n[15:8] == rx_sync_q[c] :
         (sync_mode == SYNC_BI) ? win_n == {rx_sync_q[c], sec_addr_q[c]} :
         is_sdlc ? win_n[15:8] == SDLC_FLAG : ~s_sync_n;
      wire sdlc_flag = sync_tick & ~hunt_q & is_sdlc & win_n[15:8] == SDLC_FLAG;
      wire sync_done = sync_tick & ~hunt_q & ~sdlc_flag & (bit_q == total - 4'h1);
      // only one stop bit is sampled, whatever the transmit setting
      wire async_done = tick & (state_q == RX_STOP) & bit_end;
      wire done = sync_done | async_done;
      wire hunt_wr = reg_wr & (ch == 1'(c)) & (reg_idx == PTR_RX_CTRL) &
                     host_wdata[RXC_HUNT];
      wire par_err = fm[FMT_PAR_EN] & ((^raw) ^ ~fm[FMT_PAR_EVEN]);
      wire is_lead = ~is_async & rc[RXC_STRIP] & leading_q &
                     raw[7:0] == rx_sync_q[c];
      wire addr_ok = raw[7:0] == sec_addr_q[c] | raw[7:0] == GLOBAL_ADDR;
      wire addr_chk = ~is_async & is_sdlc & rc[RXC_ADDR_SEARCH] & first_q;
      wire drop = is_lead | discard_q | (addr_chk & ~addr_ok);
      wire push = done & ~drop;
      wire [15:0] poly = tx_ctrl_q[c][TXC_CRC16] ? POLY_CRC16 : POLY_SDLC;
      wire [15:0] preset = is_sdlc ? CRC_PRESET_ONES : CRC_PRESET_ZERO;

      // parity bit stays in the byte below eight bits, drops at eight
      wire scrx_word_t word_n = '{frame_err: async_done & ~s_rxd,
                                  parity_err: par_err, data: raw[7:0]};

      assign hold_if.valid = hold_valid_q;
      assign hold_if.data = hold_q;
      assign head_if.ready = data_rd & (ch == 1'(c));
      assign head_w[c] = head_if.data;
      assign tx_gate[c] = tx_gate_q;
      assign rx_overrun[c] = overrun_q;
      assign rx_crc[c*16 +: 16] = crc_q;

      assign status_w[c] = {2'h0, ~s_cts_n, hunt_q, ~s_dcd_n, 2'h0, head_if.valid};

      wire [1:0] rx_mode = int_ctrl_q[c][IC_RX_MODE +: 2];
      wire scrx_word_t head_word = head_if.data;
      wire special = head_if.valid & (head_word.frame_err |
                     (head_word.parity_err & rx_mode != RX_MODE_NO_PAR));
      wire rx_avail = head_if.valid & rx_mode != RX_MODE_OFF;
      assign has_src[c] = special | rx_avail | tx_empty[c] | ext_change[c];
      assign src_w[c] = special ? SRC_SPECIAL : rx_avail ? SRC_RX_AVAIL :
                        tx_empty[c] ? SRC_TX_EMPTY : SRC_EXT;

      always_ff @(posedge clk) begin
         if (rst) begin
            lclk_prev_q <= 1'b0;
            tx_gate_q <= 1'b0;
            win_q <= '0;
            shift_q <= '0;
         end else begin
            lclk_prev_q <= s_lclk;
            tx_gate_q <= ~auto_en | ~s_cts_n;
            if (sync_tick) win_q <= win_n;
            if (shift_en) shift_q <= shift_n;
         end
      end

      // hunt flag: reset and a hunt write both set it, write wins
      always_ff @(posedge clk) begin
         if (rst | hunt_wr) hunt_q <= 1'b1;
         else if (sync_tick & hunt_q & sync_hit) hunt_q <= 1'b0;
      end

      // character assembly counters for both framings
      always_ff @(posedge clk) begin
         if (rst | ~rx_go) begin
            state_q <= RX_IDLE;
            tick_q <= '0;
            bit_q <= '0;
         end else if (~is_async) begin
            state_q <= RX_IDLE;
            if (sync_tick & (hunt_q | sdlc_flag | sync_done)) bit_q <= '0;
            else if (sync_tick) bit_q <= bit_q + 4'h1;
         end else if (tick) begin
            unique case (state_q)
               RX_IDLE: begin
                  tick_q <= '0;
                  bit_q <= '0;
                  // at x1 the detecting tick is already the start bit's centre
                  if (~s_rxd) state_q <= (half == 7'h00) ? RX_DATA : RX_START;
               end
               RX_START: begin
                  tick_q <= tick_q + 7'h01;
                  if (tick_q >= half) begin
                     tick_q <= '0;
                     bit_q <= '0;
                     state_q <= s_rxd ? RX_IDLE : RX_DATA;
                  end
               end
               RX_DATA: begin
                  tick_q <= bit_end ? 7'h00 : tick_q + 7'h01;
                  if (bit_end) begin
                     bit_q <= bit_q + 4'h1;
                     if (bit_q == total - 4'h1) state_q <= RX_STOP;
                  end
               end
               RX_STOP: begin
                  tick_q <= bit_end ? 7'h00 : tick_q + 7'h01;
                  if (bit_end) state_q <= RX_IDLE;
               end
            endcase
         end
      end

      // frame tracking for sync stripping and address search
      always_ff @(posedge clk) begin
         if (rst | hunt_wr | (sync_tick & hunt_q & sync_hit) | sdlc_flag) begin
            leading_q <= 1'b1;
            first_q <= 1'b1;
            discard_q <= 1'b0;
         end else if (done) begin
            if (~is_lead) leading_q <= 1'b0;
            first_q <= 1'b0;
            if (addr_chk & ~addr_ok) discard_q <= 1'b1;
         end
      end

      // CRC over each character moved when enabled, seeded from the preset after enabling
      always_ff @(posedge clk) begin
         if (rst) begin
            crc_q <= '0;
            crc_on_q <= 1'b0;
         end else if (~rc[RXC_CRC_EN]) begin
            crc_on_q <= 1'b0;
         end else if (done) begin
            crc_q <= crc_char(crc_on_q ? crc_q : preset, raw, total, poly);
            crc_on_q <= 1'b1;
         end
      end

      // holding stage ahead of the buffer; a word meeting a full hold while the buffer is full is lost
      always_ff @(posedge clk) begin
         if (rst) begin
            hold_valid_q <= 1'b0;
            hold_q <= '0;
            overrun_q <= 1'b0;
         end else begin
            overrun_q <= push & hold_valid_q & ~hold_if.ready;
            if (push & ~(hold_valid_q & ~hold_if.ready)) begin
               hold_valid_q <= 1'b1;
               hold_q <= word_n;
            end else if (hold_if.ready) begin
               hold_valid_q <= 1'b0;
            end
         end
      end
   end

   // vector read path; status-affects-vector taken from channel B copy
   wire vec_mod = int_ctrl_q[CHAN_B][IC_STATUS_VEC];
   wire src_a = has_src[CHAN_A];
   wire [2:0] vec_code = src_a ? {1'b1, src_w[CHAN_A]} : {1'b0, src_w[CHAN_B]};
   wire use_code = vec_mod & (src_a | has_src[CHAN_B]);
   wire [7:0] vec_out = {vector_q[7:4], use_code ? vec_code : vector_q[3:1],
                         vector_q[0]};
   wire [7:0] ctrl_data = (reg_idx == PTR_STATUS) ? status_w[ch] :
      ((reg_idx == PTR_VECTOR) & (ch == 1'(CHAN_B))) ? vec_out : 8'h00;
   wire scrx_word_t rd_word = head_w[ch];

   always_ff @(posedge clk) begin
      if (rst) host_rdata <= 8'h00;
      else if (ctrl_rd) host_rdata <= ctrl_data;
      else if (data_rd) host_rdata <= rd_word.data;
   end
endmodule

// *** scrx_pkg.sv ***
package scrx_pkg;
   localparam int CHANNELS = 2;
   localparam int CHAN_A = 0;
   localparam int CHAN_B = 1;
   localparam int WORD_W = 10;
   // pointer indices
   localparam logic [2:0] PTR_STATUS = 3'h0;
   localparam logic [2:0] PTR_INT_CTRL = 3'h1;
   localparam logic [2:0] PTR_VECTOR = 3'h2;
   localparam logic [2:0] PTR_RX_CTRL = 3'h3;
   localparam logic [2:0] PTR_FORMAT = 3'h4;
   localparam logic [2:0] PTR_TX_CTRL = 3'h5;
   localparam logic [2:0] PTR_SEC_ADDR = 3'h6;
   localparam logic [2:0] PTR_RX_SYNC = 3'h7;
   localparam logic [7:0] REG_RESET = 8'h00;
   // receiver_control fields
   localparam int RXC_ENABLE = 0;
   localparam int RXC_STRIP = 1;
   localparam int RXC_ADDR_SEARCH = 2;
   localparam int RXC_CRC_EN = 3;
   localparam int RXC_HUNT = 4;
   localparam int RXC_AUTO = 5;
   localparam int RXC_LEN = 6;
   // rx_tx_format_control fields
   localparam int FMT_PAR_EN = 0;
   localparam int FMT_PAR_EVEN = 1;
   localparam int FMT_STOP = 2;
   localparam int FMT_SYNC = 4;
   localparam int FMT_RATE = 6;
   // other control fields
   localparam int IC_STATUS_VEC = 2;
   localparam int IC_RX_MODE = 3;
   localparam int TXC_CRC16 = 2;
   // status_register_zero fields
   localparam int ST_RX_AVAIL = 0;
   localparam int ST_DCD = 3;
   localparam int ST_HUNT = 4;
   localparam int ST_CTS = 5;
   localparam logic [1:0] STOP_SYNC_MODE = 2'h0;
   localparam logic [1:0] SYNC_MONO = 2'h0;
   localparam logic [1:0] SYNC_BI = 2'h1;
   localparam logic [1:0] SYNC_SDLC = 2'h2;
   localparam logic [1:0] SYNC_EXT = 2'h3;
   localparam logic [1:0] RX_MODE_OFF = 2'h0;
   localparam logic [1:0] RX_MODE_NO_PAR = 2'h3;
   localparam logic [7:0] SDLC_FLAG = 8'h7E;
   localparam logic [7:0] GLOBAL_ADDR = 8'hFF;
   localparam logic [15:0] POLY_CRC16 = 16'h8005;
   localparam logic [15:0] POLY_SDLC = 16'h1021;
   localparam logic [15:0] CRC_PRESET_ONES = 16'hFFFF;
   localparam logic [15:0] CRC_PRESET_ZERO = 16'h0000;
   localparam logic [6:0] DIV_X1 = 7'h01;
   localparam logic [6:0] DIV_X16 = 7'h10;
   localparam logic [6:0] DIV_X32 = 7'h20;
   localparam logic [6:0] DIV_X64 = 7'h40;
   localparam logic [3:0] SHIFT_BITS = 4'h9;
   localparam logic [1:0] SRC_TX_EMPTY = 2'h0;
   localparam logic [1:0] SRC_EXT = 2'h1;
   localparam logic [1:0] SRC_RX_AVAIL = 2'h2;
   localparam logic [1:0] SRC_SPECIAL = 2'h3;

   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} scrx_state_t;

   typedef struct packed {
      logic frame_err;
      logic parity_err;
      logic [7:0] data;
   } scrx_word_t;

   function automatic logic [6:0] rate_ticks(input logic [1:0] r);
      rate_ticks = (r == 2'h0) ? DIV_X1 : (r == 2'h1) ? DIV_X16 :
                   (r == 2'h2) ? DIV_X32 : DIV_X64;
   endfunction

   function automatic logic [3:0] char_bits(input logic [1:0] l);
      char_bits = (l == 2'h0) ? 4'h5 : (l == 2'h1) ? 4'h7 :
                  (l == 2'h2) ? 4'h6 : 4'h8;
   endfunction
endpackage

// *** scrx_stream_if.sv ***
`timescale 1ns/1ps
interface scrx_stream_if #(parameter int W = 10);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// *** scrx_sync.sv ***
`timescale 1ns/1ps
module scrx_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

// *** scrx_buf2.sv ***
`timescale 1ns/1ps
module scrx_buf2 #(
   parameter int W = 10,
   parameter int DEPTH = 2
) (
   input wire logic clk,
   input wire logic rst,
   scrx_stream_if.snk in,
   scrx_stream_if.src out
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = DEPTH[AW:0];
   logic [W-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   wire push = in.valid & in.ready;
   wire pop = out.valid & out.ready;

   assign in.ready = (cnt_q != FULL);
   assign out.valid = (cnt_q != '0);
   assign out.data = mem_q[rd_q];

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q] <= in.data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
         if (pop) rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
         cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule

// *** scrx_top_sva.sv ***
`timescale 1ns/1ps
module scrx_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic host_cs,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic host_chan_b,
   input wire logic host_ctrl,
   input wire logic [7:0] host_wdata,
   input wire logic [7:0] host_rdata,
   input wire logic [scrx_pkg::CHANNELS-1:0] cts_n,
   input wire logic [scrx_pkg::CHANNELS-1:0] tx_gate,
   input wire logic [scrx_pkg::CHANNELS-1:0] rx_overrun,
   input wire logic [scrx_pkg::CHANNELS*16-1:0] rx_crc
);
   import scrx_pkg::*;
   // shadow of the per-channel pointers and of the fields the assertions need
   logic [1:0][2:0] ptr_q;
   logic [7:0] vec_q;
   logic ic_sv_q;
   logic [1:0] auto_q;
   wire ctl_op = host_cs && host_ctrl && (host_wr || host_rd);
   wire [2:0] cur_ptr = ptr_q[host_chan_b];
   wire rd_vec = host_cs && host_ctrl && host_rd && cur_ptr == PTR_VECTOR;
   wire rd_vec_a = rd_vec && !host_chan_b;
   wire rd_vec_b = rd_vec && host_chan_b;
   wire wr_b = host_wr && host_chan_b;
   always_ff @(posedge clk) begin
      if (rst) begin
         ptr_q <= '0;
         vec_q <= 8'h00;
         ic_sv_q <= 1'b0;
         auto_q <= 2'h0;
      end else if (ctl_op) begin
         ptr_q[host_chan_b] <= (cur_ptr == PTR_STATUS && host_wr) ? host_wdata[2:0] : PTR_STATUS;
         if (wr_b && cur_ptr == PTR_VECTOR) vec_q <= host_wdata;
         if (wr_b && cur_ptr == PTR_INT_CTRL) ic_sv_q <= host_wdata[IC_STATUS_VEC];
         if (host_wr && cur_ptr == PTR_RX_CTRL) auto_q[host_chan_b] <= host_wdata[RXC_AUTO];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_open;
      (&(~auto_q | ~cts_n))[*5];
   endsequence
   sequence s_shut_a;
      (auto_q[0] && cts_n[0])[*5];
   endsequence
   sequence s_shut_b;
      (auto_q[1] && cts_n[1])[*5];
   endsequence
   property p_vec_a_absent; rd_vec_a |=> host_rdata == 8'h00; endproperty
   property p_vec_fixed;
      rd_vec_b |=> host_rdata[7:4] == vec_q[7:4] && host_rdata[0] == vec_q[0];
   endproperty
   property p_vec_plain; rd_vec_b && !ic_sv_q |=> host_rdata[3:1] == vec_q[3:1]; endproperty
   property p_gate_open; s_open |-> &tx_gate; endproperty
   property p_gate_shut_a; s_shut_a |-> !tx_gate[0]; endproperty
   property p_gate_shut_b; s_shut_b |-> !tx_gate[1]; endproperty
   property p_rdata_holds; !(host_cs && host_rd) ##1 1'b1 |-> $stable(host_rdata); endproperty
   property p_reset_clear;
      $fell(rst) |-> host_rdata == 8'h00 && rx_crc == '0 && tx_gate == '0 && rx_overrun == '0;
   endproperty
   a_vec_a_absent: assert property (p_vec_a_absent) else $error("vector read on A");
   a_vec_fixed: assert property (p_vec_fixed) else $error("vector fixed bits");
   a_vec_plain: assert property (p_vec_plain) else $error("vector bits 3:1");
   a_gate_open: assert property (p_gate_open) else $error("transmit gate shut");
   a_gate_shut_a: assert property (p_gate_shut_a) else $error("gate A open");
   a_gate_shut_b: assert property (p_gate_shut_b) else $error("gate B open");
   a_rdata_holds: assert property (p_rdata_holds) else $error("read data moved");
   a_reset_clear: assert property (p_reset_clear) else $error("outputs after reset");
endmodule

bind scrx_top scrx_chk u_chk (.clk(clk), .rst(rst), .host_cs(host_cs), .host_wr(host_wr),
   .host_rd(host_rd), .host_chan_b(host_chan_b), .host_ctrl(host_ctrl),
   .host_wdata(host_wdata), .host_rdata(host_rdata), .cts_n(cts_n), .tx_gate(tx_gate),
   .rx_overrun(rx_overrun), .rx_crc(rx_crc));

// *** scrx_peer.sv ***
`timescale 1ns/1ps
module scrx_peer (
   output logic line_data,
   output logic line_clk
);
   initial begin
      line_data = 1'b1;
      line_clk = 1'b0;
   end
   // clock runs only during a send, from one mark bit before the frame to two after; the line idles at mark
   task automatic send(input logic [11:0] f, input int n, input int div);
      for (int i = -1; i < n + 2; i++) begin
         line_data = (i < 0 || i >= n) ? 1'b1 : f[i];
         repeat (div) begin
            #24 line_clk = 1'b1;
            #24 line_clk = 1'b0;
         end
      end
   endtask
endmodule

// *** test_serial_channel_rx_format_config.sv ***
`timescale 1ns/1ps
module test_serial_channel_rx_format_config;
   import scrx_pkg::*;
   logic clk, rst, host_cs, host_wr, host_rd, host_chan_b, host_ctrl;
   logic [7:0] host_wdata, host_rdata;
   logic [1:0] dcd_n, cts_n, sync_n, tx_empty, ext_change, tx_gate, rx_overrun;
   logic [31:0] rx_crc;
   wire [1:0] rxd, lclk;
   int n_fail = 0;
   int tests_run = 0;
   scrx_top dut (.clk(clk), .rst(rst), .host_cs(host_cs), .host_wr(host_wr), .host_rd(host_rd),
      .host_chan_b(host_chan_b), .host_ctrl(host_ctrl), .host_wdata(host_wdata),
      .host_rdata(host_rdata), .rxd(rxd), .receive_line_clock(lclk), .dcd_n(dcd_n),
      .cts_n(cts_n), .sync_n(sync_n), .tx_empty(tx_empty), .ext_change(ext_change),
      .tx_gate(tx_gate), .rx_overrun(rx_overrun), .rx_crc(rx_crc));
   scrx_peer u_peer_a (.line_data(rxd[0]), .line_clk(lclk[0]));
   scrx_peer u_peer_b (.line_data(rxd[1]), .line_clk(lclk[1]));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic bus(input logic ch, input logic ctl, input logic wr, input logic [7:0] d);
      @(negedge clk);
      host_cs = 1'b1;
      host_wr = wr;
      host_rd = !wr;
      host_chan_b = ch;
      host_ctrl = ctl;
      host_wdata = d;
      @(negedge clk);
      host_cs = 1'b0;
      host_wr = 1'b0;
      host_rd = 1'b0;
   endtask
   task automatic reg_wr(input logic ch, input logic [2:0] idx, input logic [7:0] v);
      bus(ch, 1'b1, 1'b1, {5'h00, idx});
      bus(ch, 1'b1, 1'b1, v);
   endtask
   task automatic reg_rd(input logic ch, input logic [2:0] idx, output logic [7:0] v);
      if (idx != PTR_STATUS) bus(ch, 1'b1, 1'b1, {5'h00, idx});
      bus(ch, 1'b1, 1'b0, 8'h00);
      v = host_rdata;
   endtask
   task automatic test_reset();
      logic [7:0] v;
      repeat (4) @(negedge clk);
      for (int c = 0; c < 2; c++) begin
         reg_rd(c[0], PTR_STATUS, v);
         check("status after reset", 8'h38, v & 8'h39);
      end
      $display("test reset done");
   endtask
   task automatic test_vector();
      logic [3:0] src [5] = '{4'h0, 4'h2, 4'h8, 4'h1, 4'h6};
      logic [7:0] exp [5] = '{8'hA5, 8'hA1, 8'hA3, 8'hA9, 8'hAB};
      logic [7:0] v;
      reg_wr(1'b1, PTR_VECTOR, 8'hA5);
      reg_wr(1'b0, PTR_VECTOR, 8'h3C);
      reg_rd(1'b0, PTR_VECTOR, v);
      check("vector on channel A", 8'h00, v);
      reg_rd(1'b1, PTR_VECTOR, v);
      check("vector as written", 8'hA5, v);
      reg_wr(1'b1, PTR_INT_CTRL, 8'h14);
      reg_wr(1'b0, PTR_INT_CTRL, 8'h10);
      for (int i = 0; i < 5; i++) begin
         tx_empty = src[i][1:0];
         ext_change = src[i][3:2];
         reg_rd(1'b1, PTR_VECTOR, v);
         check("modified vector", exp[i], v);
      end
      tx_empty = 2'h0;
      ext_change = 2'h0;
      $display("test vector done");
   endtask
   task automatic test_gate();
      dcd_n = 2'b11;
      cts_n = 2'b11;
      reg_wr(1'b0, PTR_RX_CTRL, 8'h20);
      reg_wr(1'b1, PTR_RX_CTRL, 8'h20);
      repeat (8) @(negedge clk);
      check("gates shut", 8'h00, {6'h00, tx_gate});
      cts_n[0] = 1'b0;
      repeat (8) @(negedge clk);
      check("gate of own channel", 8'h01, {6'h00, tx_gate});
      $display("test gate done");
   endtask
   task automatic test_rx();
      logic [31:0] tab [10] = '{32'h04013501, 32'h49415A01, 32'h8F812D01, 32'h07C1C301,
         32'h07411105, 32'hC5C1E701, 32'h04C18103, 32'h05011E09, 32'h04C05500, 32'h04E15500};
      logic [31:0] t;
      logic [11:0] f;
      logic [7:0] d, v, exp;
      logic ch, par, p;
      int len, n, div, k;
      for (int i = 0; i < 10; i++) begin
         t = tab[i];
         ch = t[3];
         par = t[24];
         len = (t[23:22] == 2'h0) ? 5 : (t[23:22] == 2'h1) ? 7 : (t[23:22] == 2'h2) ? 6 : 8;
         div = (t[31:30] == 2'h0) ? 1 : 8 << t[31:30];
         d = t[15:8] & ((8'h01 << len) - 8'h01);
         p = ^d ^ !t[25] ^ t[2];
         reg_wr(ch, PTR_FORMAT, t[31:24]);
         reg_wr(ch, PTR_RX_CTRL, t[23:16] & 8'hFE);
         reg_wr(ch, PTR_RX_CTRL, t[23:16]);
         f = {3'h0, d, 1'b0};
         n = len + 1;
         if (par) f[n] = p;
         if (par) n++;
         f[n] = !t[1];
         n++;
         if (ch) u_peer_b.send(f, n, div);
         else u_peer_a.send(f, n, div);
         k = 0;
         v = 8'h00;
         while (k < 40 && !v[ST_RX_AVAIL]) begin
            reg_rd(ch, PTR_STATUS, v);
            k++;
         end
         check("arrival", {7'h00, t[0]}, {7'h00, v[ST_RX_AVAIL]});
         if (t[0] && !v[ST_RX_AVAIL]) print_verdict();
         if (t[0]) begin
            reg_rd(1'b1, PTR_VECTOR, v);
            check("vector source", {4'hA, !ch, 1'b1, t[2] | t[1], 1'b1}, v);
            bus(ch, 1'b0, 1'b0, 8'h00);
            exp = (par && len < 8) ? (d | (8'(p) << len)) : d;
            n = len + ((par && len < 8) ? 1 : 0);
            check("character", exp, host_rdata & ((8'h01 << n) - 8'h01));
         end
      end
      $display("test receive done");
   endtask
   // register shifts msb first, data enters lsb first
   function automatic logic [15:0] crc8(input logic [15:0] s, input logic [7:0] d);
      logic [15:0] r;
      r = s;
      for (int i = 0; i < 8; i++) r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? POLY_SDLC : 16'h0000);
      return r;
   endfunction
   task automatic test_crc();
      logic [15:0] c;
      logic [7:0] dat [3] = '{8'h5A, 8'hC3, 8'h5A};
      reg_wr(1'b0, PTR_FORMAT, 8'h04);
      reg_wr(1'b0, PTR_RX_CTRL, 8'hC9);
      c = CRC_PRESET_ZERO;
      for (int i = 0; i < 3; i++) begin
         // third character follows a disable and enable, so the sum restarts
         if (i == 2) reg_wr(1'b0, PTR_RX_CTRL, 8'hC1);
         if (i == 2) reg_wr(1'b0, PTR_RX_CTRL, 8'hC9);
         if (i == 2) c = CRC_PRESET_ZERO;
         u_peer_a.send({3'h7, dat[i], 1'b0}, 10, 1);
         c = crc8(c, dat[i]);
         check("crc low", c[7:0], rx_crc[7:0]);
         check("crc high", c[15:8], rx_crc[15:8]);
      end
      $display("test crc done");
   endtask
   initial begin
      rst = 1'b1;
      host_cs = 1'b0;
      host_wr = 1'b0;
      host_rd = 1'b0;
      host_chan_b = 1'b0;
      host_ctrl = 1'b0;
      host_wdata = 8'h00;
      dcd_n = 2'b00;
      cts_n = 2'b00;
      sync_n = 2'b11;
      tx_empty = 2'h0;
      ext_change = 2'h0;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      test_reset();
      test_vector();
      test_gate();
      test_rx();
      test_crc();
      print_verdict();
   end
endmodule
